// ===== include/crc16_engine_params.svh
// Behaviour
// [R1] 16-bit checksum with polynomial 0x1021, one input byte per update.
// [R2] data port write, selector 00 loads seed low byte, 01 seed high byte.
// [R3] data port read, selector 00 gives result low byte, 01 high byte.
// [R4] selector 11 write feeds checksum; selector 10 writes, 10/11 reads reserved.
// [R5] each input byte updates the running value, starting from the seed; cpu input bytes written during an automatic run are dropped.
// [R6] software keeps selector at 11 during the automatic flash checksum.
// [R7] software sets flash start address high/low before the trigger.
// [R8] end address is 7-bit lower bound followed by nine ones.
// [R9] mode code 0x80 selects automatic flash read for checksum.
// [R10] automatic run starts only after 0x46 then 0xb9 to sequence command.
// [R11] automatic mode fetches bytes start to end and feeds each to checksum.
// [R12] mirror register reads back the last written byte bit-reversed.
// [R13] mode codes: 0x00 standby, 0x01 read, 0x02 program, 0x03 page erase.
// [R14] mode 0x04 writes protected register page, 0x05 reads it.
// [R15] 0x81/0x82 read/program with address increment; other codes reserved.
// [R16] selector sits in bits 5 and 4 of aux control, read/write.
// [R17] bytes enter MSB first, no reflection, no final inversion.
// [R18] updated result readable the cycle after a data byte write.
`ifndef CRC16_ENGINE_PARAMS_SVH
`define CRC16_ENGINE_PARAMS_SVH

`define CRC_POLY 16'h1021
`define AXI_ADDR_W 12

// register indices; byte address is four times the index
`define IDX_AUX 10'h0a2
`define IDX_DATA 10'h0b6
`define IDX_FMODE 10'h0e5
`define IDX_MIRROR 10'h0c0
`define IDX_ADRH 10'h0c1
`define IDX_ADRL 10'h0c2
`define IDX_LBOUND 10'h0c3
`define IDX_SEQUENCE_COMMAND 10'h0c4
`define IDX_STATUS 10'h0c5

`define SEL_HI 5
`define SEL_LO 4
`define DPS_BIT 0
`define SEL_SEED_LOW 2'h0
`define SEL_SEED_HIGH 2'h1
`define SEL_RESERVED 2'h2
`define SEL_INPUT 2'h3

`define MODE_STANDBY 8'h00
`define MODE_READ 8'h01
`define MODE_PROG 8'h02
`define MODE_ERASE 8'h03
`define MODE_PAGEP_WR 8'h04
`define MODE_PAGEP_RD 8'h05
`define MODE_AUTO_CRC 8'h80
`define MODE_READ_INC 8'h81
`define MODE_PROG_INC 8'h82

`define TRIG_FIRST 8'h46
`define TRIG_SECOND 8'hb9
`define END_LOW_ONES 9'h1ff

`define AUX_RESET 8'h00
`define DATA_RESET 16'h0000
`define FMODE_RESET 8'h00
`define MIRROR_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== include/crc16_engine_pkg.sv
`include "crc16_engine_params.svh"

package crc16_engine_pkg;

  typedef enum logic {RUN_IDLE, RUN_FETCH} run_state_t;

  typedef enum logic [3:0] {
    FM_STANDBY, FM_READ, FM_PROG, FM_ERASE, FM_PAGEP_WR, FM_PAGEP_RD,
    FM_AUTO_CRC, FM_READ_INC, FM_PROG_INC, FM_RESERVED
  } flash_mode_t;

  typedef struct packed {
    logic awvalid;
    logic [`AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`AXI_ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } flash_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] data;
  } flash_rsp_t;

  typedef struct packed {
    run_state_t run;
    logic [15:0] crc;
    logic [1:0] sel;
    logic dps;
    logic [7:0] fmode;
    flash_mode_t modeKind;
    logic [7:0] adrh;
    logic [7:0] adrl;
    logic [6:0] lbound;
    logic armed;
    logic [15:0] walkAddr;
    logic awTaken;
    logic [`AXI_ADDR_W-1:0] awAddr;
    logic wTaken;
    logic [7:0] wData;
    logic wStrb0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } engine_state_t;

endpackage

// ===== design/crc16_byte_step.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc16_engine_params.svh"

module crc16_byte_step #(
  parameter logic [15:0] POLY = `CRC_POLY
) (
  input wire logic [15:0] crcIn,
  input wire logic [7:0] dataIn,
  output logic [15:0] crcOut
);

  always_comb
  begin
    crcOut = crcIn;
    for (int i = 7; i >= 0; i--)
    begin
      if (crcOut[15] ^ dataIn[i]) // R17
        crcOut = {crcOut[14:0], 1'b0} ^ POLY; // R1
      else
        crcOut = {crcOut[14:0], 1'b0};
    end
  end

endmodule // crc16_byte_step

`default_nettype wire

// ===== design/bit_mirror_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc16_engine_params.svh"

module bit_mirror_reg #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic [W-1:0] wrData,
  output logic [W-1:0] rdData
);

  logic [W-1:0] storeFf;
  logic [W-1:0] nxt_store;

  always_comb
  begin
    nxt_store = wrEn ? wrData : storeFf;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      storeFf <= W'(`MIRROR_RESET);
    else
      storeFf <= nxt_store;
  end

  // mirroring is pure wiring on the stored byte
  always_comb
  begin
    for (int i = 0; i < W; i++)
      rdData[i] = storeFf[W-1-i]; // R12
  end

  mirror_read_a: assert property (@(posedge sys_clk) disable iff (reset) // R12
    wrEn |=> (rdData[0] == $past(wrData[W-1])) &&
             (rdData[W-1] == $past(wrData[0])))
    else $error("mirror byte not reversed");

endmodule // bit_mirror_reg

`default_nettype wire

// ===== design/crc16_engine.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "crc16_engine_params.svh"

module crc16_engine (
  input wire logic sys_clk,
  input wire logic reset,
  input wire crc16_engine_pkg::axi_req_t axiReq,
  output crc16_engine_pkg::axi_rsp_t axiRsp,
  output crc16_engine_pkg::flash_req_t flashReq,
  input wire crc16_engine_pkg::flash_rsp_t flashRsp,
  output crc16_engine_pkg::flash_mode_t flashMode,
  output logic autoBusy
);

  //////////////////////////////////////////////////////////////////////////////
  // state and helpers

  crc16_engine_pkg::engine_state_t q;
  crc16_engine_pkg::engine_state_t nxt_q;

  logic [9:0] wIdx;
  logic [9:0] rIdx;
  logic doWrite;
  logic dataWr;
  logic scmdWr;
  logic mirrorWr;
  logic [7:0] mirrorOut;
  logic [7:0] stepByte;
  logic [15:0] stepOut;
  logic [15:0] endAddr;
  logic flashTake;
  logic arTake;
  logic [31:0] rdMux;
  logic [1:0] rdResp;

  assign wIdx = q.awAddr[`AXI_ADDR_W-1:2];
  assign rIdx = axiReq.araddr[`AXI_ADDR_W-1:2];
  // a write lands only once both address and data have been taken
  assign doWrite = q.awTaken && q.wTaken && q.wStrb0;
  assign dataWr = doWrite && (wIdx == `IDX_DATA);
  assign scmdWr = doWrite && (wIdx == `IDX_SEQUENCE_COMMAND);
  assign mirrorWr = doWrite && (wIdx == `IDX_MIRROR);
  assign endAddr = {q.lbound, `END_LOW_ONES}; // R8
  assign flashTake = (q.run == crc16_engine_pkg::RUN_FETCH) && flashRsp.ack;
  assign arTake = axiReq.arvalid && !q.rValid;
  // the flash feed owns the checksum input while a run is active
  assign stepByte = flashTake ? flashRsp.data : q.wData; // R11

  crc16_byte_step #(
    .POLY(`CRC_POLY)
  ) crc16_byte_step_inst (
    .crcIn(q.crc),
    .dataIn(stepByte),
    .crcOut(stepOut)
  );

  bit_mirror_reg #(
    .W(8)
  ) bit_mirror_reg_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .wrEn(mirrorWr),
    .wrData(q.wData),
    .rdData(mirrorOut)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus outputs

  assign axiRsp.awready = !q.awTaken && !q.bValid;
  assign axiRsp.wready = !q.wTaken && !q.bValid;
  assign axiRsp.bvalid = q.bValid;
  assign axiRsp.bresp = q.bResp;
  assign axiRsp.arready = !q.rValid;
  assign axiRsp.rvalid = q.rValid;
  assign axiRsp.rdata = q.rData;
  assign axiRsp.rresp = q.rResp;
  assign flashReq.req = (q.run == crc16_engine_pkg::RUN_FETCH);
  assign flashReq.addr = q.walkAddr;
  assign flashMode = q.modeKind;
  assign autoBusy = (q.run == crc16_engine_pkg::RUN_FETCH);

  //////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb
  begin
    rdMux = 32'h0000_0000;
    rdResp = `RESP_OKAY;
    unique case (rIdx)
      `IDX_AUX:
      begin
        rdMux[`SEL_HI:`SEL_LO] = q.sel; // R16
        rdMux[`DPS_BIT] = q.dps;
      end
      `IDX_DATA:
      begin
        if (q.sel == `SEL_SEED_LOW)
          rdMux[7:0] = q.crc[7:0]; // R3
        else if (q.sel == `SEL_SEED_HIGH)
          rdMux[7:0] = q.crc[15:8]; // R3
        // reserved selector reads give zero
        else
          rdMux[7:0] = 8'h00; // R4
      end
      `IDX_FMODE: rdMux[7:0] = q.fmode;
      `IDX_MIRROR: rdMux[7:0] = mirrorOut; // R12
      `IDX_ADRH: rdMux[7:0] = q.adrh;
      `IDX_ADRL: rdMux[7:0] = q.adrl;
      `IDX_LBOUND: rdMux[6:0] = q.lbound;
      `IDX_SEQUENCE_COMMAND: rdMux[7:0] = 8'h00;
      `IDX_STATUS: rdMux[1:0] = {q.armed, autoBusy};
      default: rdResp = `RESP_SLVERR;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode decode

  function automatic crc16_engine_pkg::flash_mode_t decodeMode(
    input logic [7:0] code
  );
    unique case (code)
      `MODE_STANDBY: decodeMode = crc16_engine_pkg::FM_STANDBY; // R13
      `MODE_READ: decodeMode = crc16_engine_pkg::FM_READ; // R13
      `MODE_PROG: decodeMode = crc16_engine_pkg::FM_PROG; // R13
      `MODE_ERASE: decodeMode = crc16_engine_pkg::FM_ERASE; // R13
      `MODE_PAGEP_WR: decodeMode = crc16_engine_pkg::FM_PAGEP_WR; // R14
      `MODE_PAGEP_RD: decodeMode = crc16_engine_pkg::FM_PAGEP_RD; // R14
      `MODE_AUTO_CRC: decodeMode = crc16_engine_pkg::FM_AUTO_CRC; // R9
      `MODE_READ_INC: decodeMode = crc16_engine_pkg::FM_READ_INC; // R15
      `MODE_PROG_INC: decodeMode = crc16_engine_pkg::FM_PROG_INC; // R15
      default: decodeMode = crc16_engine_pkg::FM_RESERVED; // R15
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    nxt_q = q;
    // write address and data channels, taken in either order
    if (axiReq.awvalid && axiRsp.awready)
    begin
      nxt_q.awTaken = 1'b1;
      nxt_q.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready)
    begin
      nxt_q.wTaken = 1'b1;
      nxt_q.wData = axiReq.wdata[7:0];
      nxt_q.wStrb0 = axiReq.wstrb[0];
    end
    if (q.bValid && axiReq.bready)
      nxt_q.bValid = 1'b0;
    if (q.awTaken && q.wTaken)
    begin
      nxt_q.awTaken = 1'b0;
      nxt_q.wTaken = 1'b0;
      nxt_q.bValid = 1'b1;
      nxt_q.bResp = `RESP_OKAY;
      unique case (wIdx)
        `IDX_AUX, `IDX_DATA, `IDX_FMODE, `IDX_MIRROR, `IDX_ADRH,
        `IDX_ADRL, `IDX_LBOUND, `IDX_SEQUENCE_COMMAND, `IDX_STATUS: ;
        default: nxt_q.bResp = `RESP_SLVERR;
      endcase
    end
    // register effects of a landed write
    if (doWrite)
    begin
      unique case (wIdx)
        `IDX_AUX:
        begin
          nxt_q.sel = q.wData[`SEL_HI:`SEL_LO]; // R16
          nxt_q.dps = q.wData[`DPS_BIT];
        end
        `IDX_DATA:
        begin
          unique case (q.sel)
            `SEL_SEED_LOW: nxt_q.crc[7:0] = q.wData; // R2
            `SEL_SEED_HIGH: nxt_q.crc[15:8] = q.wData; // R2
            `SEL_INPUT:
            begin
              // cpu bytes are dropped while the flash walk owns the input
              if (q.run == crc16_engine_pkg::RUN_IDLE)
                nxt_q.crc = stepOut; // R4 R5 R18
            end
            `SEL_RESERVED: ; // R4
          endcase
        end
        `IDX_FMODE:
        begin
          nxt_q.fmode = q.wData; // R9
          nxt_q.armed = 1'b0;
        end
        `IDX_ADRH: nxt_q.adrh = q.wData;
        `IDX_ADRL: nxt_q.adrl = q.wData;
        `IDX_LBOUND: nxt_q.lbound = q.wData[6:0];
        `IDX_SEQUENCE_COMMAND:
        begin
          nxt_q.armed = 1'b0;
          if (q.wData == `TRIG_FIRST)
            nxt_q.armed = 1'b1; // R10
          else if (q.wData == `TRIG_SECOND && q.armed &&
                   q.fmode == `MODE_AUTO_CRC &&
                   q.run == crc16_engine_pkg::RUN_IDLE)
          begin
            nxt_q.run = crc16_engine_pkg::RUN_FETCH; // R9 R10
            nxt_q.walkAddr = {q.adrh, q.adrl}; // R7
          end
        end
        default: ;
      endcase
    end
    nxt_q.modeKind = decodeMode(nxt_q.fmode);
    // automatic walk, one byte per flash acknowledge
    if (flashTake)
    begin
      nxt_q.crc = stepOut; // R11
      if (q.walkAddr == endAddr)
        nxt_q.run = crc16_engine_pkg::RUN_IDLE; // R8
      else
        nxt_q.walkAddr = q.walkAddr + 16'h0001; // R11
    end
    // read channel
    if (q.rValid && axiReq.rready)
      nxt_q.rValid = 1'b0;
    if (arTake)
    begin
      nxt_q.rValid = 1'b1;
      nxt_q.rData = rdMux;
      nxt_q.rResp = rdResp;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      q <= '0;
      q.run <= crc16_engine_pkg::RUN_IDLE;
      q.crc <= `DATA_RESET;
      q.sel <= 2'((`AUX_RESET) >> `SEL_LO);
      q.fmode <= `FMODE_RESET;
      q.modeKind <= crc16_engine_pkg::FM_STANDBY;
    end
    else
      q <= nxt_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  input_step_a: assert property (@(posedge sys_clk) disable iff (reset) // R5
    (dataWr && q.sel == `SEL_INPUT && q.run == crc16_engine_pkg::RUN_IDLE)
    |=> q.crc == $past(stepOut))
    else $error("input byte did not update checksum");

  seed_low_a: assert property (@(posedge sys_clk) disable iff (reset) // R2
    (dataWr && q.sel == `SEL_SEED_LOW)
    |=> q.crc[7:0] == $past(q.wData) && $stable(q.crc[15:8]))
    else $error("seed low byte not loaded");

  seed_high_a: assert property (@(posedge sys_clk) disable iff (reset) // R2
    (dataWr && q.sel == `SEL_SEED_HIGH)
    |=> q.crc[15:8] == $past(q.wData) && $stable(q.crc[7:0]))
    else $error("seed high byte not loaded");

  result_read_a: assert property (@(posedge sys_clk) disable iff (reset) // R3
    (arTake && rIdx == `IDX_DATA && q.sel == `SEL_SEED_HIGH)
    |=> q.rValid && q.rData[7:0] == $past(q.crc[15:8]))
    else $error("high result byte not returned");

  reserved_read_a: assert property (@(posedge sys_clk) disable iff (reset) // R4
    (arTake && rIdx == `IDX_DATA && q.sel[1])
    |=> q.rData == 32'h0000_0000)
    else $error("reserved selector read not zero");

  walk_end_a: assert property (@(posedge sys_clk) disable iff (reset) // R8
    (flashTake && q.walkAddr == {q.lbound, `END_LOW_ONES})
    |=> q.run == crc16_engine_pkg::RUN_IDLE)
    else $error("walk ran past end address");

  no_trigger_a: assert property (@(posedge sys_clk) disable iff (reset) // R10
    (scmdWr && !q.armed && q.run == crc16_engine_pkg::RUN_IDLE)
    |=> q.run == crc16_engine_pkg::RUN_IDLE)
    else $error("run started without first trigger byte");

  auto_start_a: assert property (@(posedge sys_clk) disable iff (reset) // R9
    (scmdWr && q.wData == `TRIG_SECOND && q.armed &&
     q.fmode == `MODE_AUTO_CRC && q.run == crc16_engine_pkg::RUN_IDLE)
    |=> flashReq.req && flashReq.addr == $past({q.adrh, q.adrl}))
    else $error("trigger sequence did not start walk");

  flash_feed_a: assert property (@(posedge sys_clk) disable iff (reset) // R11
    flashTake && q.walkAddr != endAddr
    |=> q.crc == $past(stepOut) && q.walkAddr == $past(q.walkAddr) + 16'h1)
    else $error("flash byte not fed to checksum");

  mode_inc_a: assert property (@(posedge sys_clk) disable iff (reset) // R15
    q.fmode == `MODE_READ_INC
    |-> flashMode == crc16_engine_pkg::FM_READ_INC)
    else $error("increment read mode not decoded");

  sel_field_a: assert property (@(posedge sys_clk) disable iff (reset) // R16
    (arTake && rIdx == `IDX_AUX) |=> q.rData[5:4] == $past(q.sel))
    else $error("selector field not readable");

  run_done_c: cover property (@(posedge sys_clk) disable iff (reset)
    $fell(autoBusy));
  seed_then_data_c: cover property (@(posedge sys_clk) disable iff (reset)
    (dataWr && q.sel == `SEL_SEED_HIGH) ##[1:20]
    (dataWr && q.sel == `SEL_INPUT));
  slverr_c: cover property (@(posedge sys_clk) disable iff (reset)
    q.bValid && q.bResp == `RESP_SLVERR);

endmodule // crc16_engine

`default_nettype wire

// ===== tb/crc16_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc16_engine_params.svh"

module crc16_engine_tb;
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] resp;
    logic isMode;
    crc16_engine_pkg::flash_mode_t mode;
  } row_t;

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  crc16_engine_pkg::axi_req_t axiReq = '0;
  crc16_engine_pkg::axi_rsp_t axiRsp;
  crc16_engine_pkg::flash_req_t flashReq;
  crc16_engine_pkg::flash_rsp_t flashRsp = '0;
  crc16_engine_pkg::flash_mode_t flashMode;
  logic autoBusy;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int acks = 0;
  logic [15:0] expAddr = 16'h0000;
  logic [1:0] resp;
  logic [7:0] rd;
  logic [15:0] crc;

  // a reserved code (0x06) and an unmapped index sit beside the ordinary ones
  row_t rows[14] = '{
    '{`IDX_AUX, 8'hff, 8'h31, `RESP_OKAY, 1'b0, crc16_engine_pkg::FM_STANDBY},
    '{`IDX_MIRROR, 8'ha0, 8'h05, `RESP_OKAY, 1'b0, crc16_engine_pkg::FM_STANDBY},
    '{`IDX_MIRROR, 8'h01, 8'h80, `RESP_OKAY, 1'b0, crc16_engine_pkg::FM_STANDBY},
    '{`IDX_FMODE, 8'h06, 8'h06, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_RESERVED},
    '{`IDX_FMODE, 8'h01, 8'h01, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_READ},
    '{`IDX_FMODE, 8'h02, 8'h02, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_PROG},
    '{`IDX_FMODE, 8'h03, 8'h03, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_ERASE},
    '{`IDX_FMODE, 8'h04, 8'h04, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_PAGEP_WR},
    '{`IDX_FMODE, 8'h05, 8'h05, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_PAGEP_RD},
    '{`IDX_FMODE, 8'h80, 8'h80, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_AUTO_CRC},
    '{`IDX_FMODE, 8'h81, 8'h81, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_READ_INC},
    '{`IDX_FMODE, 8'h82, 8'h82, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_PROG_INC},
    '{`IDX_FMODE, 8'h00, 8'h00, `RESP_OKAY, 1'b1, crc16_engine_pkg::FM_STANDBY},
    '{10'h010, 8'h55, 8'h00, `RESP_SLVERR, 1'b0, crc16_engine_pkg::FM_STANDBY}
  };

  crc16_engine crc16_engine_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .flashReq(flashReq),
    .flashRsp(flashRsp),
    .flashMode(flashMode),
    .autoBusy(autoBusy)
  );

  always #50 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int k = 0; k < 8; k++)
      r = r[15] ? ({r[14:0], 1'b0} ^ 16'h1021) : {r[14:0], 1'b0};
    return r;
  endfunction

  function automatic logic [7:0] fdat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // each channel is sampled mid-cycle and released at the following edge
  task automatic axiWr(input logic [9:0] idx, input logic [7:0] d,
                       output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    n = 0;
    @(posedge sys_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= {idx, 2'b00};
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {24'h000000, d};
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      ta = axiReq.awvalid && axiRsp.awready;
      tw = axiReq.wvalid && axiRsp.wready;
      tb = axiRsp.bvalid === 1'b1;
      r = axiRsp.bresp;
      @(posedge sys_clk);
      if (ta) axiReq.awvalid <= 1'b0;
      if (tw) axiReq.wvalid <= 1'b0;
      n++;
    end while (!tb && n < 100);
    axiReq.bready <= 1'b0;
    if (!tb) chk("write answer", 32'h1, 32'h0);
  endtask

  task automatic axiRd(input logic [9:0] idx, output logic [7:0] d,
                       output logic [1:0] r);
    logic ta, tr;
    int n;
    n = 0;
    @(posedge sys_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= {idx, 2'b00};
    axiReq.rready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      ta = axiReq.arvalid && axiRsp.arready;
      tr = axiRsp.rvalid === 1'b1;
      d = axiRsp.rdata[7:0];
      r = axiRsp.rresp;
      @(posedge sys_clk);
      if (ta) axiReq.arvalid <= 1'b0;
      n++;
    end while (!tr && n < 100);
    axiReq.rready <= 1'b0;
    if (!tr) chk("read answer", 32'h1, 32'h0);
  endtask

  task automatic wrChk(input logic [9:0] idx, input logic [7:0] d);
    axiWr(idx, d, resp);
    chk("bresp", `RESP_OKAY, resp);
  endtask

  task automatic rdChk(input string nm, input logic [9:0] idx,
                       input logic [7:0] e);
    axiRd(idx, rd, resp);
    chk(nm, e, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // flash side acks every other cycle so a stale address is never acked
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails++;
      complete_run();
    end
    if (flashReq.req === 1'b1 && flashRsp.ack)
    begin
      acks <= acks + 1;
      chk("flash addr", expAddr, flashReq.addr);
      expAddr <= expAddr + 16'h0001;
    end
    flashRsp.ack <= !reset && flashReq.req === 1'b1 && !flashRsp.ack;
    flashRsp.data <= (flashReq.req === 1'b1 && !flashRsp.ack) ?
                     fdat(flashReq.addr) : ~flashRsp.data;
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] b;
    logic [15:0] a;
    int n;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[j])
    begin
      axiWr(rows[j].idx, rows[j].wd, resp);
      chk("table bresp", rows[j].resp, resp);
      axiRd(rows[j].idx, rd, resp);
      chk("table rdata", rows[j].rd, rd);
      chk("table rresp", rows[j].resp, resp);
      if (rows[j].isMode)
        chk("table mode", rows[j].mode, flashMode);
    end
    $display("test table done");

    // second reset after the table test, with no automatic run active
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rdChk("aux reset", `IDX_AUX, 8'h00);
    rdChk("result reset", `IDX_DATA, 8'h00);
    rdChk("mode reset", `IDX_FMODE, 8'h00);
    rdChk("mirror reset", `IDX_MIRROR, 8'h00);
    chk("mode port reset", crc16_engine_pkg::FM_STANDBY, flashMode);
    chk("busy reset", 1'b0, autoBusy);
    $display("test reset done");

    wrChk(`IDX_DATA, 8'hff);
    wrChk(`IDX_AUX, 8'h10);
    wrChk(`IDX_DATA, 8'hff);
    wrChk(`IDX_AUX, 8'h30);
    crc = 16'hffff;
    for (b = 8'h31; b <= 8'h39; b++)
    begin
      wrChk(`IDX_DATA, b);
      crc = crcStep(crc, b);
    end
    chk("model check", 16'h29b1, crc);
    rdChk("read sel 11", `IDX_DATA, 8'h00);
    wrChk(`IDX_AUX, 8'h20);
    wrChk(`IDX_DATA, 8'h5a);
    rdChk("read sel 10", `IDX_DATA, 8'h00);
    wrChk(`IDX_AUX, 8'h00);
    rdChk("result low", `IDX_DATA, crc[7:0]);
    wrChk(`IDX_AUX, 8'h10);
    rdChk("result high", `IDX_DATA, crc[15:8]);
    $display("test normal done");

    wrChk(`IDX_AUX, 8'h00);
    wrChk(`IDX_DATA, 8'h00);
    wrChk(`IDX_AUX, 8'h10);
    wrChk(`IDX_DATA, 8'h00);
    wrChk(`IDX_AUX, 8'h30);
    wrChk(`IDX_ADRH, 8'h03);
    wrChk(`IDX_ADRL, 8'hf8);
    wrChk(`IDX_LBOUND, 8'h01);
    wrChk(`IDX_FMODE, 8'h80);
    @(negedge sys_clk);
    chk("auto mode", crc16_engine_pkg::FM_AUTO_CRC, flashMode);
    // second trigger byte alone must not start a run
    wrChk(`IDX_SEQUENCE_COMMAND, 8'hb9);
    repeat (4) @(negedge sys_clk);
    chk("busy unarmed", 1'b0, autoBusy);
    expAddr = 16'h03f8;
    acks = 0;
    wrChk(`IDX_SEQUENCE_COMMAND, 8'h46);
    rdChk("status armed", `IDX_STATUS, 8'h02);
    wrChk(`IDX_SEQUENCE_COMMAND, 8'hb9);
    @(negedge sys_clk);
    chk("busy", 1'b1, autoBusy);
    // a cpu input byte lands mid-walk and must be dropped
    wrChk(`IDX_DATA, 8'h77);
    rdChk("status busy", `IDX_STATUS, 8'h01);
    n = 0;
    while (autoBusy !== 1'b0 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("auto bytes", 32'd8, acks);
    crc = 16'h0000;
    for (a = 16'h03f8; a <= 16'h03ff; a++)
      crc = crcStep(crc, fdat(a));
    wrChk(`IDX_AUX, 8'h00);
    rdChk("auto low", `IDX_DATA, crc[7:0]);
    wrChk(`IDX_AUX, 8'h10);
    rdChk("auto high", `IDX_DATA, crc[15:8]);
    $display("test auto done");
    complete_run();
  end
endmodule // crc16_engine_tb
`default_nettype wire
